// ### rtcf_pkg.sv
// constants, register map and field layouts for the rtc flags and control block
package rtcf_pkg;

  // timing: base tick runs at twice the fastest square wave
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned SQ_MAX_HZ   = 32_768;
  localparam int unsigned BASE_HZ     = 2 * SQ_MAX_HZ;
  localparam int unsigned BASE_CYC    = CLK_HZ / BASE_HZ;
  localparam int unsigned CAL_HZ      = 512;

  // divider taps: bit k of the base-tick divider toggles at BASE_HZ / 2**(k+1)
  localparam int unsigned DIV_W       = 16;
  localparam int unsigned TAP_1HZ     = 15;
  localparam int unsigned TAP_512HZ   = 6;
  localparam int unsigned TAP_4096HZ  = 3;
  localparam int unsigned TAP_32KHZ   = 0;

  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_FLAGS    = 3'h0;
  localparam logic [2:0] IDX_CENTURY  = 3'h1;
  localparam logic [2:0] IDX_ALARM    = 3'h2;
  localparam logic [2:0] IDX_SECONDS  = 3'h3;
  localparam logic [2:0] IDX_CONTROL  = 3'h4;
  localparam logic [2:0] IDX_WATCHDOG = 3'h5;
  localparam logic [2:0] IDX_IRQ_STAT = 3'h6;
  localparam logic [2:0] IDX_IRQ_MASK = 3'h7;

  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned REG_W       = 8;

  // square wave select encodings
  localparam logic [1:0] SQ_1HZ       = 2'h0;
  localparam logic [1:0] SQ_512HZ     = 2'h1;
  localparam logic [1:0] SQ_4096HZ    = 2'h2;
  localparam logic [1:0] SQ_32KHZ     = 2'h3;

  // bcd limits
  localparam logic [3:0] BCD_MAX      = 4'h9;
  localparam logic [2:0] SEC_TENS_MAX = 3'h5;

  // interrupt bit positions
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned IRQ_WD      = 0;
  localparam int unsigned IRQ_ALARM   = 1;
  localparam int unsigned IRQ_POWER   = 2;
  localparam int unsigned IRQ_BACKUP  = 3;

  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  localparam logic [7:0] RST_BYTE     = 8'h00;

  // flags register, d7 down to d0
  typedef struct packed {
    logic wd_expired;
    logic alarm_match;
    logic power_drop;
    logic osc_fail;
    logic backup_fail;
    logic cal;
    logic wr_freeze;
    logic rd_freeze;
  } rtcf_flags_s;

  // alarm seconds register: mask in d7, bcd seconds below
  typedef struct packed {
    logic       mask;
    logic [2:0] tens;
    logic [3:0] units;
  } rtcf_alarm_s;

endpackage : rtcf_pkg

// ### rtcf_props.sv
// handshake and response checker bound to the rtc flags block
`timescale 1ns/1ps
`default_nettype none

module rtcf_props #(
  parameter int unsigned BASE_CYC = 1
) (
  input wire logic                        sys_clk,
  input wire logic                        rst_n,
  input wire logic [rtcf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic [31:0]                 s_axi_wdata,
  input wire logic [3:0]                  s_axi_wstrb,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic [rtcf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic [1:0]                  s_axi_rresp,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic                        power_low,
  input wire logic                        backup_low,
  input wire logic                        osc_fail,
  input wire logic                        sq_out,
  input wire logic                        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer not two cycles after address and data");
  AST_AW_HELD: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken while one is held");
  AST_R_ERR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:5] != 3'h0
    |=> s_axi_rresp == rtcf_pkg::RESP_SLVERR)
    else $error("unmapped read not answered with slave error");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule : rtcf_props

bind rtcf_top rtcf_props #(.BASE_CYC(BASE_CYC)) u_props (.*);

`default_nettype wire

// ### rtcf_top.sv
// rtc flags/control register block with axi4-lite slave, seconds counter, watchdog and square wave
//
// Overview of operation
// - alarm seconds mask bit drops seconds comparison
// - watchdog expiry sets flag; flags read clears
// - alarm match sets flag; flags read clears
// - oscillator fail flag set, never cleared internally
// - backup fail flag follows low backup supply
// - calibration bit forces 512 Hz square wave
// - write bit freezes user time, accepts writes
// - read bit freezes user copy for snapshot
`timescale 1ns/1ps
`default_nettype none

module rtcf_top #(
  parameter int unsigned BASE_CYC = rtcf_pkg::BASE_CYC
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  // axi4-lite slave
  input  wire logic [rtcf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [rtcf_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // supply and oscillator monitors, asynchronous pins, high while the condition holds
  input  wire logic                         power_low,
  input  wire logic                         backup_low,
  input  wire logic                         osc_fail,
  output logic                              sq_out,
  output logic                              irq
);

  // ---------------- pin synchronisers ----------------
  logic [2:0] pin_raw;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  assign pin_raw = {osc_fail, backup_low, power_low};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic power_prev;
  logic backup_prev;
  wire  power_rise  = pin_sync[0] && !power_prev;
  wire  backup_rise = pin_sync[1] && !backup_prev;

  // ---------------- timebase ----------------
  logic [15:0]                   base_cnt;
  logic [rtcf_pkg::DIV_W-1:0]    div_cnt;
  wire  base_tick = (base_cnt == 16'(BASE_CYC - 1));
  // one second passes when the whole divider wraps
  wire  sec_tick  = base_tick && (&div_cnt);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_cnt <= '0;
      div_cnt  <= '0;
    end else begin
      base_cnt <= base_tick ? '0 : base_cnt + 16'h0001;
      div_cnt  <= base_tick ? div_cnt + 16'h0001 : div_cnt;
    end
  end

  // ---------------- registers ----------------
  rtcf_pkg::rtcf_flags_s flags;
  rtcf_pkg::rtcf_alarm_s alarm;
  logic [7:0]            century;
  logic [6:0]            user_sec;
  logic [6:0]            count_sec;
  logic [1:0]            square_wave_select;
  logic [7:0]            wd_reload;
  logic [7:0]            wd_count;
  logic [rtcf_pkg::IRQ_W-1:0] irq_stat;
  logic [rtcf_pkg::IRQ_W-1:0] irq_mask;
  logic                  wr_prev;

  // ---------------- axi write channel ----------------
  logic                 aw_held;
  logic [2:0]           aw_idx;
  logic                 aw_ok;
  logic                 w_held;
  logic [7:0]           w_byte;
  logic                 w_lane0;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  wire aw_fire  = s_axi_awvalid && s_axi_awready;
  wire w_fire   = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_take  = do_write && aw_ok && w_lane0;
  wire aw_in_ok = (s_axi_awaddr[7:5] == 3'h0);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held      <= 1'b0;
      aw_idx       <= '0;
      aw_ok        <= 1'b0;
      w_held       <= 1'b0;
      w_byte       <= '0;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rtcf_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[4:2];
        aw_ok   <= aw_in_ok;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (w_fire) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_ok ? rtcf_pkg::RESP_OKAY : rtcf_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wr_flags   = wr_take && (aw_idx == rtcf_pkg::IDX_FLAGS);
  wire wr_century = wr_take && (aw_idx == rtcf_pkg::IDX_CENTURY);
  wire wr_alarm   = wr_take && (aw_idx == rtcf_pkg::IDX_ALARM);
  // time writes land only while the user copy is frozen for writing
  wire wr_seconds = wr_take && (aw_idx == rtcf_pkg::IDX_SECONDS) && flags.wr_freeze;
  wire wr_control = wr_take && (aw_idx == rtcf_pkg::IDX_CONTROL);
  wire wr_wd      = wr_take && (aw_idx == rtcf_pkg::IDX_WATCHDOG);
  wire wr_mask    = wr_take && (aw_idx == rtcf_pkg::IDX_IRQ_MASK);
  // incoming byte seen through the flags layout, so no bit position is spelled out
  rtcf_pkg::rtcf_flags_s w_flags;
  assign w_flags = w_byte;

  // ---------------- axi read channel ----------------
  assign s_axi_arready = !s_axi_rvalid;
  wire       ar_fire  = s_axi_arvalid && s_axi_arready;
  wire [2:0] ar_idx   = s_axi_araddr[4:2];
  wire       ar_ok    = (s_axi_araddr[7:5] == 3'h0);
  wire       rd_flags = ar_fire && ar_ok && (ar_idx == rtcf_pkg::IDX_FLAGS);
  wire       rd_stat  = ar_fire && ar_ok && (ar_idx == rtcf_pkg::IDX_IRQ_STAT);

  logic [7:0] rd_byte;
  always_comb begin
    case (ar_idx)
      rtcf_pkg::IDX_FLAGS:    rd_byte = flags;
      rtcf_pkg::IDX_CENTURY:  rd_byte = century;
      rtcf_pkg::IDX_ALARM:    rd_byte = alarm;
      rtcf_pkg::IDX_SECONDS:  rd_byte = {1'b0, user_sec};
      rtcf_pkg::IDX_CONTROL:  rd_byte = {6'h00, square_wave_select};
      rtcf_pkg::IDX_WATCHDOG: rd_byte = wd_reload;
      rtcf_pkg::IDX_IRQ_STAT: rd_byte = {4'h0, irq_stat};
      rtcf_pkg::IDX_IRQ_MASK: rd_byte = {4'h0, irq_mask};
      default:                rd_byte = rtcf_pkg::RST_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= rtcf_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, ar_ok ? rd_byte : rtcf_pkg::RST_BYTE};
      s_axi_rresp  <= ar_ok ? rtcf_pkg::RESP_OKAY : rtcf_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- seconds counter ----------------
  logic [6:0] next_count_sec;
  always_comb begin
    if (count_sec[3:0] != rtcf_pkg::BCD_MAX) begin
      next_count_sec = count_sec + 7'h01;
    end else if (count_sec[6:4] != rtcf_pkg::SEC_TENS_MAX) begin
      next_count_sec = {count_sec[6:4] + 3'h1, 4'h0};
    end else begin
      next_count_sec = 7'h00;
    end
  end

  wire wr_release = wr_prev && !flags.wr_freeze;
  wire copy_user  = !flags.wr_freeze && !flags.rd_freeze && !wr_release;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_sec <= '0;
      user_sec  <= '0;
      wr_prev   <= 1'b0;
    end else begin
      wr_prev <= flags.wr_freeze;
      // loading wins over a tick in the same cycle
      if (wr_release) begin
        count_sec <= user_sec;
      end else if (sec_tick) begin
        count_sec <= next_count_sec;
      end
      if (wr_seconds) begin
        user_sec <= w_byte[6:0];
      end else if (copy_user) begin
        user_sec <= count_sec;
      end
    end
  end

  // ---------------- events ----------------
  // a masked seconds field matches on every second
  wire alarm_hit = sec_tick && (alarm.mask || (next_count_sec == {alarm.tens, alarm.units}));
  wire wd_expire = sec_tick && (wd_count == 8'h01);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_reload <= rtcf_pkg::RST_BYTE;
      wd_count  <= rtcf_pkg::RST_BYTE;
    end else if (wr_wd) begin
      wd_reload <= w_byte;
      wd_count  <= w_byte;
    end else if (sec_tick && (wd_count != 8'h00)) begin
      wd_count <= wd_count - 8'h01;
    end
  end

  // ---------------- flags ----------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags       <= '0;
      power_prev  <= 1'b0;
      backup_prev <= 1'b0;
    end else begin
      power_prev  <= pin_sync[0];
      backup_prev <= pin_sync[1];
      // hardware set wins over the read clear
      flags.wd_expired  <= wd_expire || (flags.wd_expired && !rd_flags);
      flags.alarm_match <= alarm_hit || (flags.alarm_match && !rd_flags);
      flags.power_drop  <= power_rise || (flags.power_drop && !rd_flags);
      // only software writing zero may clear it
      flags.osc_fail    <= pin_sync[2] || (flags.osc_fail && !(wr_flags && !w_flags.osc_fail));
      flags.backup_fail <= pin_sync[1];
      if (wr_flags) begin
        flags.cal       <= w_flags.cal;
        flags.wr_freeze <= w_flags.wr_freeze;
        flags.rd_freeze <= w_flags.rd_freeze;
      end
    end
  end

  // ---------------- other writable registers ----------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      century            <= rtcf_pkg::RST_BYTE;
      alarm              <= '0;
      square_wave_select <= rtcf_pkg::SQ_1HZ;
      irq_mask           <= '0;
    end else begin
      // a nibble above nine is refused, the old digit stays
      if (wr_century && (w_byte[7:4] <= rtcf_pkg::BCD_MAX)) begin
        century[7:4] <= w_byte[7:4];
      end
      if (wr_century && (w_byte[3:0] <= rtcf_pkg::BCD_MAX)) begin
        century[3:0] <= w_byte[3:0];
      end
      if (wr_alarm) begin
        alarm <= w_byte;
      end
      if (wr_control) begin
        square_wave_select <= w_byte[1:0];
      end
      if (wr_mask) begin
        irq_mask <= w_byte[rtcf_pkg::IRQ_W-1:0];
      end
    end
  end

  // ---------------- interrupts ----------------
  logic [rtcf_pkg::IRQ_W-1:0] irq_event;
  always_comb begin
    irq_event                       = '0;
    irq_event[rtcf_pkg::IRQ_WD]     = wd_expire;
    irq_event[rtcf_pkg::IRQ_ALARM]  = alarm_hit;
    irq_event[rtcf_pkg::IRQ_POWER]  = power_rise;
    irq_event[rtcf_pkg::IRQ_BACKUP] = backup_rise;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= irq_event | (rd_stat ? '0 : irq_stat);
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // ---------------- square wave ----------------
  logic sq_sel;
  always_comb begin
    case (square_wave_select)
      rtcf_pkg::SQ_1HZ:    sq_sel = div_cnt[rtcf_pkg::TAP_1HZ];
      rtcf_pkg::SQ_512HZ:  sq_sel = div_cnt[rtcf_pkg::TAP_512HZ];
      rtcf_pkg::SQ_4096HZ: sq_sel = div_cnt[rtcf_pkg::TAP_4096HZ];
      rtcf_pkg::SQ_32KHZ:  sq_sel = div_cnt[rtcf_pkg::TAP_32KHZ];
      default:             sq_sel = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sq_out <= 1'b0;
    end else begin
      sq_out <= flags.cal ? div_cnt[rtcf_pkg::TAP_512HZ] : sq_sel;
    end
  end

endmodule : rtcf_top

`default_nettype wire

// ### test_rtc_flags_and_control.sv
// register-level testbench for the rtc flags and control block
`timescale 1ns/1ps
`default_nettype none

module test_rtc_flags_and_control;
  logic                        sys_clk;
  logic                        rst_n;
  logic [rtcf_pkg::ADDR_W-1:0] s_axi_awaddr;
  logic                        s_axi_awvalid;
  logic                        s_axi_awready;
  logic [31:0]                 s_axi_wdata;
  logic [3:0]                  s_axi_wstrb;
  logic                        s_axi_wvalid;
  logic                        s_axi_wready;
  logic [1:0]                  s_axi_bresp;
  logic                        s_axi_bvalid;
  logic                        s_axi_bready;
  logic [rtcf_pkg::ADDR_W-1:0] s_axi_araddr;
  logic                        s_axi_arvalid;
  logic                        s_axi_arready;
  logic [31:0]                 s_axi_rdata;
  logic [1:0]                  s_axi_rresp;
  logic                        s_axi_rvalid;
  logic                        s_axi_rready;
  logic                        power_low;
  logic                        backup_low;
  logic                        osc_fail;
  logic                        sq_out;
  logic                        irq;
  logic [31:0]                 rdat;
  logic [1:0]                  resp;
  int                          n_fail;
  int                          compares;
  int                          cyc;
  int                          n;

  // one base tick per clock keeps a second at 65536 cycles
  rtcf_top #(.BASE_CYC(1)) dut (.*);

  always #20 sys_clk = ~sys_clk;

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk($sformatf("reg %h", a), {24'h0, e}, rdat);
    chk("rresp", {30'h0, rtcf_pkg::RESP_OKAY}, {30'h0, resp});
  endtask : rc

  // edges counted between two sq_out changes
  task automatic half();
    logic v;
    n = 0;
    v = sq_out;
    while (sq_out === v && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    v = sq_out;
    while (sq_out === v && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : half

  initial begin
    {sys_clk, rst_n, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, power_low, backup_low, osc_fail} = '0;
    s_axi_wstrb = 4'hf;
    {n_fail, compares, cyc} = '0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rc(8'h00, 8'h00);
    rc(8'h04, 8'h00);
    rd(8'h20);
    chk("rresp unmapped", {30'h0, rtcf_pkg::RESP_SLVERR}, {30'h0, resp});
    wr(8'h20, 8'h55);
    chk("bresp unmapped", {30'h0, rtcf_pkg::RESP_SLVERR}, {30'h0, resp});
    $display("test reset and map done");
    wr(8'h04, 8'h21);
    chk("bresp", {30'h0, rtcf_pkg::RESP_OKAY}, {30'h0, resp});
    rc(8'h04, 8'h21);
    wr(8'h04, 8'h3a);
    rc(8'h04, 8'h31);
    wr(8'h04, 8'ha5);
    rc(8'h04, 8'h35);
    $display("test century done");
    power_low <= 1'b1;
    backup_low <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    power_low <= 1'b0;
    wr(8'h1c, 8'h04);
    repeat (2) @(posedge sys_clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rc(8'h00, 8'h28);
    rc(8'h00, 8'h08);
    rc(8'h18, 8'h0c);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    backup_low <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rc(8'h00, 8'h00);
    $display("test supply flags done");
    osc_fail <= 1'b1;
    repeat (8) @(posedge sys_clk);
    osc_fail <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rc(8'h00, 8'h10);
    rc(8'h00, 8'h10);
    wr(8'h00, 8'h00);
    rc(8'h00, 8'h00);
    $display("test oscillator flag done");
    wr(8'h00, 8'h04);
    for (int s = 0; s < 4; s++) begin
      wr(8'h10, 8'(s));
      half();
      chk("sq half period cal", 32'd64, n);
    end
    wr(8'h00, 8'h00);
    half();
    chk("sq half period 32k", 32'd1, n);
    wr(8'h10, 8'h02);
    half();
    chk("sq half period 4k", 32'd8, n);
    wr(8'h10, 8'h01);
    half();
    chk("sq half period 512", 32'd64, n);
    $display("test square wave done");
    wr(8'h0c, 8'h12);
    rc(8'h0c, 8'h00);
    wr(8'h00, 8'h02);
    wr(8'h0c, 8'h58);
    rc(8'h0c, 8'h58);
    wr(8'h08, 8'h59);
    wr(8'h14, 8'h01);
    wr(8'h1c, 8'h03);
    wr(8'h00, 8'h01);
    // a whole second may pass before the first tick
    for (int i = 0; i < 66000 && irq !== 1'b1; i++) @(posedge sys_clk);
    chk("irq tick", 32'h1, {31'h0, irq});
    rc(8'h0c, 8'h58);
    rc(8'h00, 8'hc1);
    rc(8'h00, 8'h01);
    wr(8'h00, 8'h00);
    rc(8'h0c, 8'h59);
    rc(8'h18, 8'h03);
    $display("test time and alarm done");
    give_verdict();
  end
endmodule : test_rtc_flags_and_control

`default_nettype wire
